// ===== ebpm_ext_dev.sv
// external device: drives only the bits the mux leaves undriven
`timescale 1ns/100ps
module ebpm_ext_dev (
  input wire ebpm_pkg::ebpm_pin_drv_t drv_in,
  input wire logic [15:0] ext_in,
  output logic [15:0] pin_out
);
  import ebpm_pkg::*;
  assign pin_out = (drv_in.o & drv_in.oe) | (ext_in & ~drv_in.oe);
endmodule

// ===== ebpm_pin_mux.sv
// pin mux for the data port and address port with external bus override
`timescale 1ns/100ps
// Behaviour
// - per-bit direction control on both ports
// - input pins have output driver off
// - bus takes data port when enabled
// - demux: low byte data, high byte per width
// - mux: low byte is address/data bits 0-7
// - demux: address port drives 16-bit address
// - after demux-to-mux switch, keep driving address
module ebpm_pin_mux
  import ebpm_pkg::*;
#(
  parameter int W = ebpm_pkg::PORT_W
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire ebpm_pkg::ebpm_port_cfg_t data_cfg_in,
  input wire ebpm_pkg::ebpm_port_cfg_t addr_cfg_in,
  input wire ebpm_pkg::ebpm_bus_req_t bus_in,
  input wire logic [15:0] data_port_pin_in,
  input wire logic [15:0] address_port_pin_in,
  output ebpm_pkg::ebpm_pin_drv_t data_port_out,
  output ebpm_pkg::ebpm_pin_drv_t address_port_out,
  output logic [15:0] data_port_rd_out,
  output logic [15:0] address_port_rd_out,
  output logic addr_hold_out
);
  import ebpm_pkg::*;

  // lane split: low lane is the first byte, high lane the rest of the port
  localparam int LO_MSB = BYTE_W - 1;
  localparam int HI_LSB = BYTE_W;
  localparam int HI_MSB = W - 1;
  // address port ownership is released while in reset
  localparam logic HOLD_RST = 1'h0;

  // what one byte lane of the data port carries in the current cycle
  typedef enum logic [1:0] {
    EBPM_LANE_GPIO,
    EBPM_LANE_ADDR,
    EBPM_LANE_DATA
  } ebpm_lane_src_t;

  logic addr_hold_q;
  logic addr_hold_d;
  logic addr_owned;
  ebpm_pin_drv_t dp_q;
  ebpm_pin_drv_t dp_d;
  ebpm_pin_drv_t ap_q;
  ebpm_pin_drv_t ap_d;
  ebpm_pin_drv_t dp_gpio;
  ebpm_pin_drv_t ap_gpio;
  ebpm_lane_src_t lo_src;
  ebpm_lane_src_t hi_src;
  logic [W-1:0] lo_o;
  logic [W-1:0] lo_oe;
  logic [W-1:0] hi_o;
  logic [W-1:0] hi_oe;
  logic [W-1:0] dp_sync;
  logic [W-1:0] ap_sync;

  // pin levels are asynchronous to clk_in
  ebpm_sync #(
    .W(W)
  ) u_dsync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .d_in(data_port_pin_in),
    .q_out(dp_sync)
  );

  ebpm_sync #(
    .W(W)
  ) u_async (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .d_in(address_port_pin_in),
    .q_out(ap_sync)
  );

  // general-purpose drive: latch value where output, off where input
  function automatic ebpm_pin_drv_t gpio_drv(input ebpm_port_cfg_t c);
    ebpm_pin_drv_t r;
    r.o = c.latch & c.dir;
    r.oe = c.dir;
    return r;
  endfunction

  // source of one lane; the same decode serves both lanes
  function automatic ebpm_lane_src_t lane_pick(
    input ebpm_bus_req_t b,
    input logic high
  );
    ebpm_lane_src_t s;
    s = EBPM_LANE_GPIO;
    unique case (b.mode)
      EBPM_BUS_DEMUX: begin
        // narrow width leaves the high lane to software
        if (!high || b.wide) begin
          s = EBPM_LANE_DATA;
        end
      end
      EBPM_BUS_MUX: begin
        if (b.addr_phase) begin
          s = EBPM_LANE_ADDR;
        end else if (!high || b.wide) begin
          s = EBPM_LANE_DATA;
        end else begin
          // narrow data phase: high lane holds address bits instead of floating
          s = EBPM_LANE_ADDR;
        end
      end
      EBPM_BUS_OFF: begin
        s = EBPM_LANE_GPIO;
      end
      default: begin
        // unused mode code behaves as bus off
        s = EBPM_LANE_GPIO;
      end
    endcase
    return s;
  endfunction

  // value a lane drives for its source
  function automatic logic [W-1:0] lane_o(
    input ebpm_lane_src_t s,
    input ebpm_bus_req_t b,
    input logic [W-1:0] gpio
  );
    logic [W-1:0] v;
    v = gpio;
    unique case (s)
      EBPM_LANE_ADDR: begin
        v = b.addr[W-1:0];
      end
      EBPM_LANE_DATA: begin
        v = b.wdata[W-1:0];
      end
      EBPM_LANE_GPIO: begin
        v = gpio;
      end
      default: begin
        v = gpio;
      end
    endcase
    return v;
  endfunction

  // address lanes always drive; data lanes follow the bus direction
  function automatic logic [W-1:0] lane_oe(
    input ebpm_lane_src_t s,
    input ebpm_bus_req_t b,
    input logic [W-1:0] gpio
  );
    logic [W-1:0] e;
    e = gpio;
    unique case (s)
      EBPM_LANE_ADDR: begin
        e = '1;
      end
      EBPM_LANE_DATA: begin
        e = {W{b.data_oe}};
      end
      EBPM_LANE_GPIO: begin
        e = gpio;
      end
      default: begin
        e = gpio;
      end
    endcase
    return e;
  endfunction

  assign dp_gpio = gpio_drv(data_cfg_in);
  assign ap_gpio = gpio_drv(addr_cfg_in);
  assign lo_src = lane_pick(bus_in, 1'h0);
  assign hi_src = lane_pick(bus_in, 1'h1);
  assign lo_o = lane_o(lo_src, bus_in, dp_gpio.o);
  assign lo_oe = lane_oe(lo_src, bus_in, dp_gpio.oe);
  assign hi_o = lane_o(hi_src, bus_in, dp_gpio.o);
  assign hi_oe = lane_oe(hi_src, bus_in, dp_gpio.oe);
  // address port belongs to the bus in demux, in mux only when entered from demux
  assign addr_owned = (bus_in.mode == EBPM_BUS_DEMUX) ||
    (bus_in.mode == EBPM_BUS_MUX && addr_hold_q);

  // ownership: taken by demux, kept through mux, dropped by anything else
  always_comb begin
    addr_hold_d = addr_hold_q;
    unique case (bus_in.mode)
      EBPM_BUS_OFF: begin
        addr_hold_d = 1'h0;
      end
      EBPM_BUS_DEMUX: begin
        addr_hold_d = 1'h1;
      end
      EBPM_BUS_MUX: begin
        addr_hold_d = addr_hold_q;
      end
      default: begin
        addr_hold_d = 1'h0;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      addr_hold_q <= HOLD_RST;
    end else begin
      addr_hold_q <= addr_hold_d;
    end
  end

  // data port: lanes pick their source apart, so a narrow demux bus leaves
  // the high lane to software
  always_comb begin
    dp_d.o = {hi_o[HI_MSB:HI_LSB], lo_o[LO_MSB:0]};
    dp_d.oe = {hi_oe[HI_MSB:HI_LSB], lo_oe[LO_MSB:0]};
  end

  // registered pin drive keeps outputs glitch free
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dp_q <= '{o: RST_LATCH, oe: RST_DIR};
    end else begin
      dp_q <= dp_d;
    end
  end

  // address port: bus address overrides software while owned
  always_comb begin
    ap_d = ap_gpio;
    if (addr_owned) begin
      ap_d.o = bus_in.addr;
      ap_d.oe = '1;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ap_q <= '{o: RST_LATCH, oe: RST_DIR};
    end else begin
      ap_q <= ap_d;
    end
  end

  assign data_port_out = dp_q;
  assign address_port_out = ap_q;
  assign data_port_rd_out = dp_sync;
  assign address_port_rd_out = ap_sync;
  assign addr_hold_out = addr_hold_q;
endmodule

// ===== ebpm_pkg.sv
// shared types and constants for the external bus port pin mux
package ebpm_pkg;
  localparam int PORT_W = 16;
  localparam int BYTE_W = 8;
  localparam logic [15:0] RST_LATCH = 16'h0000;
  localparam logic [15:0] RST_DIR = 16'h0000;

  typedef enum logic [1:0] {
    EBPM_BUS_OFF,
    EBPM_BUS_DEMUX,
    EBPM_BUS_MUX
  } ebpm_mode_t;

  // software view of one port: output latch and direction (1 = output)
  typedef struct packed {
    logic [15:0] latch;
    logic [15:0] dir;
  } ebpm_port_cfg_t;

  // bus controller request for the pins
  typedef struct packed {
    ebpm_mode_t mode;
    logic wide;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic data_oe;
    logic addr_phase;
  } ebpm_bus_req_t;

  // drive value and output enable of a group of two-way pins
  typedef struct packed {
    logic [15:0] o;
    logic [15:0] oe;
  } ebpm_pin_drv_t;
endpackage

// ===== ebpm_props.sv
// checker on the pin mux ports
`timescale 1ns/100ps
module ebpm_props
  import ebpm_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire ebpm_pkg::ebpm_port_cfg_t data_cfg_in,
  input wire ebpm_pkg::ebpm_port_cfg_t addr_cfg_in,
  input wire ebpm_pkg::ebpm_bus_req_t bus_in,
  input wire ebpm_pkg::ebpm_pin_drv_t data_port_out,
  input wire ebpm_pkg::ebpm_pin_drv_t address_port_out,
  input wire logic addr_hold_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  wire ebpm_pin_drv_t d = data_port_out;
  wire logic off = bus_in.mode == EBPM_BUS_OFF;
  wire logic dmx = bus_in.mode == EBPM_BUS_DEMUX;
  wire logic mux = bus_in.mode == EBPM_BUS_MUX;
  sequence s_sw; dmx ##1 mux; endsequence
  sequence s_cold; off ##1 mux; endsequence
  gpio_drive_a: assert property (off |=> d.oe == $past(data_cfg_in.dir) &&
    d.o == $past(data_cfg_in.latch & data_cfg_in.dir)) else $error("gpio");
  dmx_lo_a: assert property (dmx && bus_in.data_oe
    |=> d.o[7:0] == $past(bus_in.wdata[7:0]) && &d.oe[7:0]) else $error("lo");
  dmx_hi_a: assert property (dmx && !bus_in.wide
    |=> d.oe[15:8] == $past(data_cfg_in.dir[15:8]) &&
    d.o[15:8] == $past(data_cfg_in.latch[15:8] & data_cfg_in.dir[15:8])) else $error("hi");
  mux_ad_a: assert property (mux && bus_in.addr_phase
    |=> d.o == $past(bus_in.addr) && &d.oe) else $error("ad");
  mux_data_a: assert property (mux && !bus_in.addr_phase
    |=> d.o[7:0] == $past(bus_in.wdata[7:0]) &&
    d.oe[7:0] == ($past(bus_in.data_oe) ? 8'hFF : 8'h00)) else $error("ad data");
  dmx_addr_a: assert property (dmx
    |=> address_port_out.o == $past(bus_in.addr) && &address_port_out.oe) else $error("a");
  keep_addr_a: assert property (s_sw |=> addr_hold_out && &address_port_out.oe &&
    address_port_out.o == $past(bus_in.addr)) else $error("kept");
  cold_mux_a: assert property (s_cold |=> !addr_hold_out &&
    address_port_out.oe == $past(addr_cfg_in.dir)) else $error("cold");
endmodule
bind ebpm_pin_mux ebpm_props ebpm_props_inst (.*);

// ===== ebpm_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module ebpm_sync #(
  parameter int W = 16
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= d_in;
      s2_q <= s1_q;
    end
  end
  assign q_out = s2_q;
endmodule

// ===== external_bus_port_pin_mux_test.sv
// bench for the pin mux
`timescale 1ns/100ps
module external_bus_port_pin_mux_test;
  import ebpm_pkg::*;
  logic clk_in = 1'h0, rstn_in = 1'h0, hold;
  ebpm_port_cfg_t c = '0;
  ebpm_bus_req_t b = '0;
  ebpm_pin_drv_t dp, ap;
  logic [15:0] pin, rd, ard;
  int fail_count = 0, n_tests = 0;
  always #12.5 clk_in = ~clk_in;
  ebpm_pin_mux ebpm_pin_mux_inst (.clk_in, .rstn_in, .data_cfg_in(c), .addr_cfg_in(c),
    .bus_in(b), .data_port_pin_in(pin), .address_port_pin_in(ap.o | ~ap.oe),
    .data_port_out(dp), .address_port_out(ap), .data_port_rd_out(rd),
    .address_port_rd_out(ard), .addr_hold_out(hold));
  ebpm_ext_dev ebpm_ext_dev_inst (.drv_in(dp), .ext_in(16'hC3A5), .pin_out(pin));
  task chk(input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t %h %h", $time, e, g);
    end
  endtask
  // rd lags the pins by two edges, so four covers every output
  task go(input ebpm_port_cfg_t nc, input ebpm_bus_req_t nb);
    @(posedge clk_in);
    c <= nc;
    b <= nb;
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
  endtask
  task t_gpio;
    go('{16'hFFFF, 16'h0F0F}, '0);
    chk(16'h0F0F, dp.oe);
    chk(16'h0F0F, dp.o);
    chk(16'hCFAF, rd);
    chk(16'hFFFF, ard);
    $display("gpio done");
  endtask
  task t_bus;
    go('{16'h5A00, 16'hFF00}, '{EBPM_BUS_DEMUX, 1'h0, 16'h1234, 16'hABCD, 1'h1, 1'h0});
    chk(16'h5ACD, dp.o);
    chk(16'h1234, ap.o);
    chk(16'h1234, ard);
    chk(16'h0001, {15'h0000, hold});
    go(c, '{EBPM_BUS_DEMUX, 1'h1, 16'h1234, 16'hABCD, 1'h1, 1'h0});
    chk(16'hABCD, dp.o);
    go(c, '{EBPM_BUS_DEMUX, 1'h1, 16'h1234, 16'hABCD, 1'h0, 1'h0});
    chk(16'h0000, dp.oe);
    chk(16'hC3A5, rd);
    go(c, '{EBPM_BUS_MUX, 1'h1, 16'h5678, 16'hABCD, 1'h1, 1'h1});
    chk(16'h5678, dp.o);
    chk(16'hFFFF, ap.oe);
    go(c, '{EBPM_BUS_MUX, 1'h0, 16'h5678, 16'hABCD, 1'h1, 1'h0});
    chk(16'h56CD, dp.o);
    chk(16'h5678, ap.o);
    go(c, '0);
    chk(16'h0000, {15'h0000, hold});
    go(c, '{EBPM_BUS_MUX, 1'h1, 16'h5678, 16'hABCD, 1'h1, 1'h1});
    chk(16'hFF00, ap.oe);
    $display("bus done");
  endtask
  task print_verdict;
    $display("%0d checks, %0d bad", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_in);
    rstn_in <= 1'h1;
    t_gpio;
    t_bus;
    print_verdict;
  end
  initial begin
    #25000;
    fail_count++;
    print_verdict;
  end
endmodule
